// ===== ldc_regs.sv
/*
 Configuration register bank of an 8-channel LED driver: a 288-bit configuration image
 written word by word over Avalon-MM, decoded into per-group and per-channel settings,
 and a read-only status image. Assumes one clock and an active-low async reset pin.
*/
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
module ldc_regs #(
	parameter int NCH = ldc_pkg::NCH
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Avalon-MM slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	// Status image source, from logic on this clock
	input wire logic [ldc_pkg::CFG_W-1:0] status_i,
	// Decoded settings
	output ldc_pkg::ldc_fields_t fields_o,
	output logic apply_o
);
	// Reset release
	logic rst_s1_q;
	logic rst_s2_q;
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DONE} ldc_state_t;

	ldc_state_t state_q;
	ldc_state_t state_d;
	ldc_pkg::ldc_req_t req;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] resp_q;
	logic [1:0] resp_d;
	logic wait_q;
	logic wait_d;
	logic apply_q;
	logic apply_d;
	logic [ldc_pkg::CFG_W-1:0] status_q;
	logic [NCH*ldc_pkg::DC_W-1:0] first_dc;
	logic [NCH*ldc_pkg::DC_W-1:0] second_dc;
	logic [ldc_pkg::CFG_W-1:0] image;
	logic [31:0] mem_rdata;
	logic mem_we;
	logic [3:0] mem_idx;
	logic in_cfg;
	logic [31:0] wmask;
	logic [31:0] merged;
	ldc_pkg::ldc_fields_t fields_q;
	ldc_pkg::ldc_fields_t fields_d;

	// Word index is byte address bits 9:2; the two low address bits are ignored
	assign req.read = avs_read_i;
	assign req.write = avs_write_i;
	assign req.index = avs_address_i[9:2];
	assign req.wdata = avs_writedata_i;

	assign in_cfg = req.index >= ldc_pkg::CFG_BASE_IDX &&
		req.index < ldc_pkg::CFG_BASE_IDX + 8'(ldc_pkg::WORDS);
	assign mem_idx = 4'(req.index - ldc_pkg::CFG_BASE_IDX);

	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
	end
	assign merged = (req.wdata & wmask) | (mem_rdata & ~wmask);

	// Write lands only once the word has been read back, keeping byte lanes honest
	assign mem_we = state_q == ST_READ && req.write && in_cfg;

	ldc_word_mem #(
		.DEPTH(ldc_pkg::WORDS)
	) u_mem (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_s2_q),
		.we_i(mem_we),
		.waddr_i(mem_idx),
		.wdata_i(merged),
		.raddr_i(mem_idx),
		.rdata_o(mem_rdata),
		.image_o(image)
	);

	// Bus handshake: idle, one cycle for the word read, answer
	always_comb begin
		state_d = state_q;
		rdata_d = rdata_q;
		resp_d = resp_q;
		wait_d = 1'b1;
		apply_d = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (req.read || req.write) begin
					state_d = ST_READ;
				end
			end
			ST_READ: begin
				state_d = ST_DONE;
				wait_d = 1'b0;
				resp_d = 2'h0;
				rdata_d = 32'h0000_0000;
				if (in_cfg) begin
					rdata_d = mem_rdata;
					apply_d = req.write;
				end else if (req.index == ldc_pkg::STATUS_IDX) begin
					rdata_d = status_q[31:0];
					if (req.write) begin
						resp_d = 2'h2;
					end
				end else if (req.index >= ldc_pkg::STATUS_IDX + 8'h01 &&
					req.index < ldc_pkg::STATUS_IDX + 8'(ldc_pkg::WORDS)) begin
					rdata_d = status_q[32*(req.index - ldc_pkg::STATUS_IDX) +: 32];
					if (req.write) begin
						resp_d = 2'h2;
					end
				end else begin
					// Unmapped: reads zero, writes dropped, slave error answered
					resp_d = 2'h2;
				end
			end
			ST_DONE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			state_q <= ST_IDLE;
			rdata_q <= 32'h0000_0000;
			resp_q <= 2'h0;
			wait_q <= 1'b1;
			apply_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rdata_q <= rdata_d;
			resp_q <= resp_d;
			wait_q <= wait_d;
			apply_q <= apply_d;
		end
	end

	// Status snapshot, zero in reset, then registered from status_i every cycle
	always_ff @(posedge ref_clk_i or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			status_q <= '0;
		end else begin
			status_q <= status_i;
		end
	end

	// One slice per channel; the reserved middle of each stride is never read
	for (genvar n = 0; n < NCH; n++) begin : g_chan
		assign first_dc[n*ldc_pkg::DC_W +: ldc_pkg::DC_W] = image[n*ldc_pkg::CH_STRIDE +: ldc_pkg::DC_W];
		assign second_dc[n*ldc_pkg::DC_W +: ldc_pkg::DC_W] =
			image[n*ldc_pkg::CH_STRIDE + ldc_pkg::SECOND_DC_OFS +: ldc_pkg::DC_W];
	end

	// Field decode; reserved bits never reach a field
	always_comb begin
		fields_d.test_current_40ua = image[ldc_pkg::NEIGHBOR_CUR_BIT];
		fields_d.test_cycles = image[ldc_pkg::NEIGHBOR_DUR_BIT] ?
			12'(ldc_pkg::TEST_CYC_HI) : 12'(ldc_pkg::TEST_CYC_LO);
		unique case (image[ldc_pkg::GRAY_MODE_LSB +: 2])
			ldc_pkg::GRAY_MODE_10: fields_d.gray_bits = ldc_pkg::GRAY_BITS_10;
			ldc_pkg::GRAY_MODE_8: fields_d.gray_bits = ldc_pkg::GRAY_BITS_8;
			default: fields_d.gray_bits = ldc_pkg::GRAY_BITS_12;
		endcase
		fields_d.timing_reset_en = image[ldc_pkg::TIMING_RESET_BIT];
		fields_d.auto_repeat_en = image[ldc_pkg::AUTO_REPEAT_BIT];
		fields_d.second_range_high = image[ldc_pkg::SECOND_RANGE_BIT];
		fields_d.first_range_high = image[ldc_pkg::FIRST_RANGE_BIT];
		fields_d.second_group_brightness = image[ldc_pkg::SECOND_BC_LSB +: ldc_pkg::BC_W];
		fields_d.first_group_brightness = image[ldc_pkg::FIRST_BC_LSB +: ldc_pkg::BC_W];
		fields_d.first_group_channel_correction = first_dc;
		fields_d.second_group_channel_correction = second_dc;
	end

	always_ff @(posedge ref_clk_i or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			fields_q <= '0;
		end else begin
			fields_q <= fields_d;
		end
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign avs_response_o = resp_q;
	assign fields_o = fields_q;
	assign apply_o = apply_q;
endmodule

// ===== ldc_pkg.sv
/*
 Package for the LED driver configuration register bank: word map, field positions,
 reset values and the decoded-field carrier. Assumes a 32-bit Avalon-MM slave.
*/
package ldc_pkg;

	// Geometry of the wide configuration and status images
	localparam int CFG_W = 288;
	localparam int WORDS = 9;
	localparam int NCH = 8;
	localparam int DC_W = 7;
	localparam int BC_W = 8;
	localparam int CH_STRIDE = 21;
	localparam int SECOND_DC_OFS = 14;

	// Register indices (byte address is four times the index)
	localparam logic [7:0] STATUS_IDX = 8'h02;
	localparam logic [7:0] CFG_BASE_IDX = 8'h10;
	localparam logic [7:0] CTRL_IDX = 8'h20;

	// Field positions inside the configuration image
	localparam int NEIGHBOR_CUR_BIT = 200;
	localparam int NEIGHBOR_DUR_BIT = 199;
	localparam int GRAY_MODE_LSB = 197;
	localparam int TIMING_RESET_BIT = 196;
	localparam int AUTO_REPEAT_BIT = 195;
	localparam int SECOND_RANGE_BIT = 194;
	localparam int FIRST_RANGE_BIT = 192;
	localparam int SECOND_BC_LSB = 184;
	localparam int FIRST_BC_LSB = 168;

	// Reset values
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [31:0] STATUS_RST = 32'h0000_0000;

	// Gray counter width encodings
	localparam logic [1:0] GRAY_MODE_10 = 2'h2;
	localparam logic [1:0] GRAY_MODE_8 = 2'h3;
	localparam logic [3:0] GRAY_BITS_12 = 4'hC;
	localparam logic [3:0] GRAY_BITS_10 = 4'hA;
	localparam logic [3:0] GRAY_BITS_8 = 4'h8;

	// Adjacent-pin test settings in their own units
	localparam int TEST_CUR_LO_UA = 20;
	localparam int TEST_CUR_HI_UA = 40;
	localparam int TEST_DUR_LO_US = 10;
	localparam int TEST_DUR_HI_US = 20;
	localparam int CLK_MHZ = 125;
	localparam int TEST_CYC_LO = TEST_DUR_LO_US * CLK_MHZ;
	localparam int TEST_CYC_HI = TEST_DUR_HI_US * CLK_MHZ;

	typedef struct packed {
		logic test_current_40ua;
		logic [11:0] test_cycles;
		logic [3:0] gray_bits;
		logic timing_reset_en;
		logic auto_repeat_en;
		logic second_range_high;
		logic first_range_high;
		logic [BC_W-1:0] second_group_brightness;
		logic [BC_W-1:0] first_group_brightness;
		logic [NCH*DC_W-1:0] first_group_channel_correction;
		logic [NCH*DC_W-1:0] second_group_channel_correction;
	} ldc_fields_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] index;
		logic [31:0] wdata;
	} ldc_req_t;

endpackage

// ===== ldc_word_mem.sv
/*
 Word store for the configuration image, one register per 32-bit word.
 Assumes the caller decodes the word index and keeps it below the depth.
*/
`timescale 1ns/10ps
module ldc_word_mem #(
	parameter int DEPTH = 9
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Write port
	input wire logic we_i,
	input wire logic [3:0] waddr_i,
	input wire logic [31:0] wdata_i,
	// Registered read port and full image
	input wire logic [3:0] raddr_i,
	output logic [31:0] rdata_o,
	output logic [DEPTH*32-1:0] image_o
);
	logic [DEPTH*32-1:0] mem_q;
	logic [DEPTH*32-1:0] mem_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	always_comb begin
		mem_d = mem_q;
		rdata_d = 32'h0000_0000;
		for (int i = 0; i < DEPTH; i++) begin
			if (we_i && waddr_i == 4'(i)) begin
				mem_d[i*32 +: 32] = wdata_i;
			end
			if (raddr_i == 4'(i)) begin
				rdata_d = mem_q[i*32 +: 32];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_q <= '0;
			rdata_q <= ldc_pkg::WORD_RST;
		end else begin
			mem_q <= mem_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;
	assign image_o = mem_q;
endmodule

// ===== ldc_regs_chk.sv
/*
 Bus and decoded-field assertions for the LED driver configuration bank.
 Assumes 32-bit Avalon-MM access and reset released through two flops.
*/
`timescale 1ns/10ps
module ldc_regs_chk (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Bus
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] avs_response_o,
	// Settings
	input wire ldc_pkg::ldc_fields_t fields_o,
	input wire logic apply_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	logic [7:0] idx;
	logic ans;
	assign idx = avs_address_i[9:2];
	assign ans = !avs_waitrequest_o;
	test_time_a: assert property ($past(nrst_i, 6) |-> fields_o.test_cycles inside {12'h4E2, 12'h9C4})
		else $error("test duration count off");
	gray_codes_a: assert property ($past(nrst_i, 6) |-> fields_o.gray_bits inside {4'hC, 4'hA, 4'h8})
		else $error("gray width code off");
	field_hold_a: assert property ($past(nrst_i, 6) && !$stable(fields_o) |-> $past(apply_o) || $past(apply_o, 2))
		else $error("fields changed without a write");
	status_ro_a: assert property (avs_write_i && ans && idx inside {[8'h02:8'h0A]} |-> avs_response_o == 2'h2 && !apply_o)
		else $error("status write not refused");
	cfg_apply_a: assert property (avs_write_i && ans && idx inside {[8'h10:8'h18]} |-> avs_response_o == 2'h0 && apply_o)
		else $error("config write not applied");
	apply_cause_a: assert property (apply_o |-> avs_write_i && ans)
		else $error("apply without write");
	unmapped_rd_a: assert property (avs_read_i && ans && !(idx inside {[8'h02:8'h0A], [8'h10:8'h18]})
		|-> avs_readdata_o == 32'h0 && avs_response_o == 2'h2)
		else $error("unmapped read not empty");
	idle_wait_a: assert property (!avs_read_i && !avs_write_i |-> avs_waitrequest_o)
		else $error("answer without request");
	bus_answer_a: assert property (avs_read_i || avs_write_i |-> ##[0:3] ans)
		else $error("no answer in time");
endmodule
bind ldc_regs ldc_regs_chk ldc_regs_chk_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o), .fields_o(fields_o), .apply_o(apply_o));

// ===== ldc_status_src.sv
/*
 Model of the status logic feeding the bank's read-only image.
 Assumes a static image with a distinct low byte per word is enough to prove word order.
*/
`timescale 1ns/10ps
module ldc_status_src (
	// Status image toward the block
	output logic [287:0] status_o
);
	// Non-zero pattern so a dropped word cannot read as reset; low byte numbers the word
	for (genvar k = 0; k < 9; k++) begin : g_word
		assign status_o[32*k +: 32] = {24'hA5C30F, 8'h90 + 8'(k)};
	end
endmodule

// ===== tb_top.sv
/*
 Self-checking bench for the configuration bank.
 Assumes ldc_pkg, ldc_regs and the status model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [9:0] avs_address_i = 10'h000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [1:0] avs_response_o;
	logic [287:0] status_i;
	ldc_pkg::ldc_fields_t fields_o;
	int n_fail = 0;
	int compares = 0;
	logic [31:0] q;
	logic [1:0] r;
	always #4 ref_clk_i = ~ref_clk_i;
	ldc_status_src ldc_status_src_i (.status_o(status_i));
	ldc_regs ldc_regs_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.avs_response_o(avs_response_o), .status_i(status_i), .fields_o(fields_o), .apply_o());
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task give_verdict;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Request held up to the edge that sees waitrequest low; answer taken at that edge
	task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		avs_address_i <= {idx, 2'b00};
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		@(posedge ref_clk_i);
		while (avs_waitrequest_o !== 1'b0) begin
			n++;
			if (n > 20) begin
				n_fail++;
				give_verdict();
			end
			@(posedge ref_clk_i);
		end
		q = avs_readdata_o;
		r = avs_response_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	// Apply pulse and field update land within three edges
	task settle;
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	task t_defaults;
		settle();
		chk("cycles", fields_o.test_cycles, 32'(ldc_pkg::TEST_CYC_LO));
		chk("gray", fields_o.gray_bits, 32'hC);
		chk("bright", {fields_o.second_group_brightness, fields_o.first_group_brightness}, 32'h0);
		bus(1'b0, 8'h16, 32'h0);
		chk("word6", q, 32'h0);
		$display("defaults done");
	endtask
	task t_function;
		logic [1:0] m;
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			d = {23'h0, m[0], m[1], m, m, m[0], 1'b0, m[1]};
			bus(1'b1, 8'h16, d);
			settle();
			chk("cur", fields_o.test_current_40ua, m[0]);
			chk("cycles", fields_o.test_cycles, m[1] ? 32'(ldc_pkg::TEST_CYC_HI) : 32'(ldc_pkg::TEST_CYC_LO));
			chk("enables", {fields_o.timing_reset_en, fields_o.auto_repeat_en}, m);
			chk("gray", fields_o.gray_bits, m == 2'h3 ? 32'h8 : m == 2'h2 ? 32'hA : 32'hC);
			chk("ranges", {fields_o.second_range_high, fields_o.first_range_high}, {m[0], m[1]});
		end
		bus(1'b1, 8'h15, 32'h5A00_3C00);
		settle();
		chk("bright2", fields_o.second_group_brightness, 32'h5A);
		chk("bright1", fields_o.first_group_brightness, 32'h3C);
		$display("function done");
	endtask
	task t_correction;
		logic [31:0] d;
		d = {4'h0, 7'h55, 7'h2B, 7'h00, 7'h11};
		bus(1'b1, 8'h10, d);
		settle();
		chk("dc1_ch0", fields_o.first_group_channel_correction[6:0], 32'h11);
		chk("dc2_ch0", fields_o.second_group_channel_correction[6:0], 32'h2B);
		chk("dc1_ch1", fields_o.first_group_channel_correction[13:7], 32'h55);
		bus(1'b0, 8'h10, 32'h0);
		chk("word0", q, d);
		$display("correction done");
	endtask
	task t_status;
		bus(1'b0, 8'h02, 32'h0);
		chk("status", q, 32'hA5C3_0F90);
		chk("resp", r, 32'h0);
		bus(1'b0, 8'h0A, 32'h0);
		chk("status_w8", q, 32'hA5C3_0F98);
		bus(1'b1, 8'h02, 32'h0);
		chk("ro_resp", r, 32'h2);
		bus(1'b0, 8'h30, 32'h0);
		chk("unmapped", {r, q[29:0]}, 32'h8000_0000);
		chk("unmapped_q", q, 32'h0);
		$display("status done");
	endtask
	initial begin
		repeat (5) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		t_defaults();
		t_function();
		t_correction();
		t_status();
		give_verdict();
	end
endmodule
